// [rtl/flash_mode_pkg.sv]
// constants, device map and types for the flash mode controller
package flash_mode_pkg;
  // clock and timing
  localparam int unsigned CLK_MHZ         = 25;
  localparam int unsigned DF_SETUP_NS     = 4000;
  localparam int unsigned DF_SETUP_CYCLES = (DF_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W           = 16;

  // software port map (byte addresses)
  localparam int unsigned ADDR_W   = 8;
  localparam logic [7:0] A_CMD     = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_IRQSTAT = 8'h08;
  localparam logic [7:0] A_IRQMASK = 8'h0c;
  localparam logic [7:0] A_CTRL    = 8'h10;
  localparam logic [7:0] A_FREQ    = 8'h14;

  // device register map
  localparam logic [7:0] DEV_DF_ACCESS_CTL = 8'h00;
  localparam logic [7:0] DEV_MODE_CTL      = 8'h01;
  localparam logic [7:0] DEV_FREQ_SET      = 8'h02;
  localparam int unsigned DF_EN_BIT        = 0;

  // command word fields and operations
  localparam int unsigned OP_LSB  = 0;
  localparam int unsigned ARG_LSB = 8;
  localparam logic [2:0] OP_INIT  = 3'h1;
  localparam logic [2:0] OP_DFACC = 3'h2;
  localparam logic [2:0] OP_MODE  = 3'h3;
  localparam logic [2:0] OP_CHECK = 3'h4;

  // request codes
  localparam logic [7:0] ACCESS_DISABLE_REQ = 8'h00;
  localparam logic [7:0] ACCESS_ENABLE_REQ  = 8'h01;
  localparam logic [7:0] REQ_CODE_PROG      = 8'h01;
  localparam logic [7:0] REQ_DATA_PROG      = 8'h02;
  localparam logic [7:0] REQ_CODE_TO_NONPRG = 8'h03;
  localparam logic [7:0] REQ_DATA_TO_NONPRG = 8'h04;

  // mode register read-back values
  localparam logic [7:0] RD_NONPROG   = 8'h08;
  localparam logic [7:0] RD_CODE_PROG = 8'h82;
  localparam logic [7:0] RD_DATA_PROG = 8'h10;

  // result codes
  localparam logic [7:0] RES_OK       = 8'h00;
  localparam logic [7:0] RES_PARAM    = 8'h10;
  localparam logic [7:0] RES_MISMATCH = 8'h11;

  // frequency range and threshold in MHz
  localparam logic [7:0] FREQ_MIN    = 8'h02;
  localparam logic [7:0] FREQ_MAX    = 8'h28;
  localparam logic [7:0] FREQ_THRESH = 8'h17;

  // status and interrupt bits
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_INIT    = 1;
  localparam int unsigned ST_DFEN    = 2;
  localparam int unsigned ST_DFRDY   = 3;
  localparam int unsigned ST_RES_LSB = 8;
  localparam int unsigned IRQ_DONE   = 0;
  localparam int unsigned IRQ_ERR    = 1;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } dev_req_t;

  typedef enum logic [3:0] {
    S_IDLE, S_START, S_WAITIDLE, S_RDMODE, S_DECIDE, S_WRMODE, S_SETTLE,
    S_WRFREQ, S_RDCHK, S_RDCHKW, S_DFSETUP, S_FINISH
  } fsm_t;

  typedef struct packed {
    fsm_t             st;
    logic [2:0]       op;
    logic [7:0]       arg;
    logic [7:0]       result;
    logic             busy;
    logic             initDone;
    logic [7:0]       freqVal;
    logic             dfEnable;
    logic             dfReady;
    logic [CNT_W-1:0] cnt;
    logic [7:0]       modeRd;
    logic [1:0]       irqStat;
    logic [1:0]       irqMask;
    logic             intEnSw;
    logic [31:0]      rdata;
    dev_req_t         dev;
    logic             cpuIntEn;
    logic             irq;
    logic [1:0]       busySync1;
    logic [1:0]       busySync2;
  } ctrl_state_t;
endpackage

// [rtl/flash_mode_ctrl.sv]
// flash mode and data-flash access controller driving the device registers
// Notes on behaviour
// [R01] data-flash reads only while access enable set
// [R02] disable or unknown code clears access enable
// [R03] wait 4 us setup after enabling access
// [R04] change access enable only in non-programmable mode
// [R05] mode register written per request code
// [R06] settle wait inserted after mode write
// [R07] interrupts masked around mode write and settle
// [R08] load converted frequency after interrupt restore
// [R09] unknown mode code acts as code 0x04
// [R10] report 0x00 on match, 0x11 on mismatch
// [R11] programming modes entered only from non-programmable
// [R12] start mode change only when sequencers idle
// [R13] frequency init required before mode change
// [R14] frequency value from MHz with threshold 23
// [R15] frequency accepted only from 2 to 40
// [R16] mode read-back 0x08, 0x82, 0x10 confirms mode
//
// Local design decisions: the register offsets and the address-and-strobe port.
module flash_mode_ctrl #(
  parameter int unsigned MODE_SETTLE_CYCLES = 16,
  parameter logic [7:0]  WR_NONPROG         = 8'h08,
  parameter logic [7:0]  WR_CODE_PROG       = 8'h82,
  parameter logic [7:0]  WR_DATA_PROG       = 8'h10
) (
  input  wire logic                   mclk,
  input  wire logic                   arst_n,
  input  wire logic [7:0]             swAddr,
  input  wire logic [31:0]            swWdata,
  input  wire logic                   swWe,
  input  wire logic                   swRe,
  output logic [31:0]                 swRdata,
  output flash_mode_pkg::dev_req_t    devReq,
  input  wire logic [7:0]             devRdata,
  input  wire logic                   seqBusy,
  input  wire logic                   extraBusy,
  output logic                        cpuIntEn,
  output logic                        dfReady,
  output logic                        irq
);
  // whole controller state lives in one registered word; n is its next value
  flash_mode_pkg::ctrl_state_t s;
  flash_mode_pkg::ctrl_state_t n;

  // read-back value that the requested mode must show
  function automatic logic [7:0] expectedMode(input logic [7:0] code);
    case (code)
      flash_mode_pkg::REQ_CODE_PROG: expectedMode = flash_mode_pkg::RD_CODE_PROG; // [R16]
      flash_mode_pkg::REQ_DATA_PROG: expectedMode = flash_mode_pkg::RD_DATA_PROG; // [R16]
      default:                       expectedMode = flash_mode_pkg::RD_NONPROG;   // [R09]
    endcase
  endfunction

  // value written to the mode register for a request
  function automatic logic [7:0] writeCode(input logic [7:0] code);
    case (code)
      flash_mode_pkg::REQ_CODE_PROG: writeCode = WR_CODE_PROG; // [R05]
      flash_mode_pkg::REQ_DATA_PROG: writeCode = WR_DATA_PROG; // [R05]
      default:                       writeCode = WR_NONPROG;   // [R05] [R09]
    endcase
  endfunction

  // true for the two codes that enter a programming mode
  function automatic logic isProgReq(input logic [7:0] code);
    isProgReq = (code == flash_mode_pkg::REQ_CODE_PROG) || (code == flash_mode_pkg::REQ_DATA_PROG);
  endfunction

  // converted frequency setting, 9-bit sum avoids overflow
  function automatic logic [7:0] convFreq(input logic [7:0] mhz);
    logic [8:0] sum;
    sum = {1'b0, mhz} + {1'b0, flash_mode_pkg::FREQ_THRESH};
    if (mhz <= flash_mode_pkg::FREQ_THRESH) begin
      convFreq = mhz - 8'h01; // [R14]
    end else begin
      convFreq = sum[8:1];    // [R14]
    end
  endfunction

  // counter loads: a wait ends on the cycle that sees zero, so one less
  // is loaded to make the wait last exactly the stated number of cycles
  localparam logic [flash_mode_pkg::CNT_W-1:0] SETTLE_LOAD =
    flash_mode_pkg::CNT_W'(MODE_SETTLE_CYCLES - 1);
  localparam logic [flash_mode_pkg::CNT_W-1:0] DF_SETUP_LOAD =
    flash_mode_pkg::CNT_W'(flash_mode_pkg::DF_SETUP_CYCLES - 1);

  // event pulses and the decoded access request
  logic [1:0] irqSet;
  logic [1:0] irqClr;
  logic       crit;
  logic       dfOn;

  // next-state logic for the whole controller
  always_comb begin
    n = s;
    irqSet = 2'h0;
    irqClr = 2'h0;
    dfOn = (s.arg == flash_mode_pkg::ACCESS_ENABLE_REQ);
    // device strobes and read data are one-cycle pulses by default
    n.dev.we = 1'b0;
    n.dev.re = 1'b0;
    n.rdata = 32'h0;
    // busy pins come from another domain
    n.busySync1 = {extraBusy, seqBusy};
    n.busySync2 = s.busySync1;

    // software writes; commands while busy are dropped
    if (swWe) begin
      case (swAddr)
        // a command word carries its operation and one argument byte
        flash_mode_pkg::A_CMD: begin
          if (!s.busy) begin
            n.op = swWdata[flash_mode_pkg::OP_LSB +: 3];
            n.arg = swWdata[flash_mode_pkg::ARG_LSB +: 8];
            n.busy = 1'b1;
            n.st = flash_mode_pkg::S_START;
          end
        end
        flash_mode_pkg::A_IRQSTAT: irqClr = swWdata[1:0];
        flash_mode_pkg::A_IRQMASK: n.irqMask = swWdata[1:0];
        flash_mode_pkg::A_CTRL:    n.intEnSw = swWdata[0];
        default: ;
      endcase
    end

    // software reads, data in the following cycle
    if (swRe) begin
      case (swAddr)
        flash_mode_pkg::A_CMD: n.rdata = {16'h0, s.arg, 5'h0, s.op};
        flash_mode_pkg::A_STATUS: begin
          n.rdata[flash_mode_pkg::ST_BUSY] = s.busy;
          n.rdata[flash_mode_pkg::ST_INIT] = s.initDone;
          n.rdata[flash_mode_pkg::ST_DFEN] = s.dfEnable;
          n.rdata[flash_mode_pkg::ST_DFRDY] = s.dfReady;
          n.rdata[flash_mode_pkg::ST_RES_LSB +: 8] = s.result;
        end
        flash_mode_pkg::A_IRQSTAT: n.rdata = {30'h0, s.irqStat};
        flash_mode_pkg::A_IRQMASK: n.rdata = {30'h0, s.irqMask};
        flash_mode_pkg::A_CTRL:    n.rdata = {31'h0, s.intEnSw};
        flash_mode_pkg::A_FREQ:    n.rdata = {24'h0, s.freqVal};
        default:                   n.rdata = 32'h0;
      endcase
    end

    // command sequencer
    case (s.st)
      // nothing to do until software writes a command
      flash_mode_pkg::S_IDLE: ;
      // init completes here; the other operations first need the device
      flash_mode_pkg::S_START: begin
        case (s.op)
          flash_mode_pkg::OP_INIT: begin
            if (s.arg >= flash_mode_pkg::FREQ_MIN && s.arg <= flash_mode_pkg::FREQ_MAX) begin // [R15]
              n.initDone = 1'b1;
              n.freqVal = convFreq(s.arg); // [R14]
              n.result = flash_mode_pkg::RES_OK;
            end else begin
              n.result = flash_mode_pkg::RES_PARAM; // [R15]
            end
            n.st = flash_mode_pkg::S_FINISH;
          end
          flash_mode_pkg::OP_DFACC,
          flash_mode_pkg::OP_MODE,
          flash_mode_pkg::OP_CHECK: n.st = flash_mode_pkg::S_WAITIDLE;
          default: begin
            n.result = flash_mode_pkg::RES_PARAM;
            n.st = flash_mode_pkg::S_FINISH;
          end
        endcase
      end
      flash_mode_pkg::S_WAITIDLE: begin
        // hold off until both sequencers are idle
        // busy is looked at only before the first access; a sequencer
        // started in mid-change is not guarded, firmware must not do that
        if (s.busySync2 == 2'h0) begin // [R12]
          n.dev.re = 1'b1;
          n.dev.addr = flash_mode_pkg::DEV_MODE_CTL;
          n.st = flash_mode_pkg::S_RDMODE;
        end
      end
      // the device port answers in the cycle of the read strobe,
      // so the mode is taken here with no extra wait state
      flash_mode_pkg::S_RDMODE: begin
        n.modeRd = devRdata;
        n.st = flash_mode_pkg::S_DECIDE;
      end
      // act on the mode just read; a refused request writes nothing
      flash_mode_pkg::S_DECIDE: begin
        n.st = flash_mode_pkg::S_FINISH;
        case (s.op)
          flash_mode_pkg::OP_DFACC: begin
            if (s.modeRd != flash_mode_pkg::RD_NONPROG) begin // [R04]
              n.result = flash_mode_pkg::RES_MISMATCH;
            end else begin
              n.dev.we = 1'b1;
              n.dev.addr = flash_mode_pkg::DEV_DF_ACCESS_CTL;
              n.dev.wdata = 8'h00;
              n.dev.wdata[flash_mode_pkg::DF_EN_BIT] = dfOn; // [R02]
              n.dfEnable = dfOn;
              n.dfReady = 1'b0; // [R01]
              if (dfOn) begin
                n.cnt = DF_SETUP_LOAD; // [R03]
                n.st = flash_mode_pkg::S_DFSETUP;
              end else begin
                n.result = flash_mode_pkg::RES_OK;
              end
            end
          end
          // refuse first: no init yet, or programming entered from programming
          flash_mode_pkg::OP_MODE: begin
            if (!s.initDone) begin
              n.result = flash_mode_pkg::RES_PARAM; // [R13]
            end else if (isProgReq(s.arg) && s.modeRd != flash_mode_pkg::RD_NONPROG) begin
              n.result = flash_mode_pkg::RES_MISMATCH; // [R11]
            end else begin
              n.dev.we = 1'b1;
              n.dev.addr = flash_mode_pkg::DEV_MODE_CTL;
              n.dev.wdata = writeCode(s.arg); // [R05]
              n.st = flash_mode_pkg::S_WRMODE;
            end
          end
          default: begin
            // plain mode check
            if (s.modeRd == expectedMode(s.arg)) begin // [R10]
              n.result = flash_mode_pkg::RES_OK;
            end else begin
              n.result = flash_mode_pkg::RES_MISMATCH;
            end
          end
        endcase
      end
      // mode write is out this cycle, interrupts already masked
      flash_mode_pkg::S_WRMODE: begin
        n.cnt = SETTLE_LOAD; // [R06]
        n.st = flash_mode_pkg::S_SETTLE;
      end
      // settle wait; a slower device needs a larger parameter
      flash_mode_pkg::S_SETTLE: begin
        if (s.cnt == '0) begin
          n.st = flash_mode_pkg::S_WRFREQ; // [R06]
        end else begin
          n.cnt = s.cnt - 1'b1;
        end
      end
      flash_mode_pkg::S_WRFREQ: begin
        // interrupts already restored here
        n.dev.we = 1'b1;
        n.dev.addr = flash_mode_pkg::DEV_FREQ_SET;
        n.dev.wdata = s.freqVal; // [R08]
        n.st = flash_mode_pkg::S_RDCHK;
      end
      // read the mode back to confirm the change took effect
      flash_mode_pkg::S_RDCHK: begin
        n.dev.re = 1'b1;
        n.dev.addr = flash_mode_pkg::DEV_MODE_CTL;
        n.st = flash_mode_pkg::S_RDCHKW;
      end
      // compare in the cycle the device answers
      flash_mode_pkg::S_RDCHKW: begin
        if (devRdata == expectedMode(s.arg)) begin // [R10] [R16]
          n.result = flash_mode_pkg::RES_OK;
        end else begin
          n.result = flash_mode_pkg::RES_MISMATCH;
        end
        n.st = flash_mode_pkg::S_FINISH;
      end
      // data-flash reads stay blocked until the setup time has run
      flash_mode_pkg::S_DFSETUP: begin
        if (s.cnt == '0) begin
          n.dfReady = 1'b1; // [R01] [R03]
          n.result = flash_mode_pkg::RES_OK;
          n.st = flash_mode_pkg::S_FINISH;
        end else begin
          n.cnt = s.cnt - 1'b1;
        end
      end
      // free the command port; events show one cycle later
      flash_mode_pkg::S_FINISH: begin
        n.busy = 1'b0;
        irqSet[flash_mode_pkg::IRQ_DONE] = 1'b1;
        irqSet[flash_mode_pkg::IRQ_ERR] = (s.result != flash_mode_pkg::RES_OK);
        n.st = flash_mode_pkg::S_IDLE;
      end
      default: n.st = flash_mode_pkg::S_IDLE;
    endcase

    // set wins over a same-cycle clear
    n.irqStat = (s.irqStat & ~irqClr) | irqSet;
    n.irq = |(n.irqStat & n.irqMask);
    // mask from the mode write through the settle wait, then restore
    crit = (n.st == flash_mode_pkg::S_WRMODE) || (n.st == flash_mode_pkg::S_SETTLE);
    n.cpuIntEn = crit ? 1'b0 : n.intEnSw; // [R07]
  end

  // single state register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign swRdata = s.rdata;
  assign devReq = s.dev;
  assign cpuIntEn = s.cpuIntEn;
  assign dfReady = s.dfReady;
  assign irq = s.irq;
endmodule

// [bench/flash_mode_monitor.sv]
// port checker for the flash mode controller
module flash_mode_monitor #(
  parameter int unsigned MODE_SETTLE_CYCLES = 16
) (
  input wire logic                     mclk,
  input wire logic                     arst_n,
  input wire flash_mode_pkg::dev_req_t devReq,
  input wire logic [7:0]               devRdata,
  input wire logic                     seqBusy,
  input wire logic                     extraBusy,
  input wire logic                     cpuIntEn,
  input wire logic                     dfReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       modeWr, freqWr, enWr, modeRd;
  logic [7:0] lastMode_reg, sinceMode_reg, sinceEn_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // decoded device writes
  assign modeWr = devReq.we && devReq.addr == flash_mode_pkg::DEV_MODE_CTL;
  assign freqWr = devReq.we && devReq.addr == flash_mode_pkg::DEV_FREQ_SET;
  assign enWr   = devReq.we && devReq.addr == flash_mode_pkg::DEV_DF_ACCESS_CTL;
  // the device port answers in the cycle of the read strobe
  assign modeRd = devReq.re && devReq.addr == flash_mode_pkg::DEV_MODE_CTL;
  // last mode read back; counters saturate so long idle spans stay harmless
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lastMode_reg  <= 8'h00;
      sinceMode_reg <= 8'h00;
      sinceEn_reg   <= 8'h00;
    end else begin
      lastMode_reg  <= modeRd ? devRdata : lastMode_reg;
      sinceMode_reg <= modeWr ? 8'h00 : sinceMode_reg + 8'(sinceMode_reg != 8'hff);
      sinceEn_reg   <= enWr && devReq.wdata[0] ? 8'h00 : sinceEn_reg + 8'(sinceEn_reg != 8'hff);
    end
  end
  mode_wr_masked_a: assert property (modeWr |-> !cpuIntEn)
    else $error("interrupts open at mode write");
  settle_masked_a: assert property (modeWr |=> !cpuIntEn [*2])
    else $error("interrupts open during settle");
  settle_wait_a: assert property (freqWr |-> sinceMode_reg >= 8'(MODE_SETTLE_CYCLES))
    else $error("frequency load before settle");
  freq_follows_a: assert property (modeWr |-> ##[1:300] freqWr)
    else $error("no frequency load after mode write");
  mode_code_a: assert property (modeWr |-> devReq.wdata inside {8'h08, 8'h82, 8'h10})
    else $error("bad mode code written");
  prog_entry_a: assert property (modeWr && devReq.wdata != 8'h08 |-> lastMode_reg == 8'h08)
    else $error("programming entered from programming");
  dfacc_mode_a: assert property (enWr |-> lastMode_reg == 8'h08)
    else $error("access changed outside non-programmable");
  seq_idle_a: assert property (seqBusy [*5] |-> !(devReq.re || devReq.we))
    else $error("device access while sequencer busy");
  extra_idle_a: assert property (extraBusy [*5] |-> !(devReq.re || devReq.we))
    else $error("device access while extra busy");
  df_setup_a: assert property ($rose(dfReady) |-> sinceEn_reg >= 8'(flash_mode_pkg::DF_SETUP_CYCLES - 1))
    else $error("data flash ready too early");
  df_off_a: assert property (enWr && !devReq.wdata[0] |=> !dfReady)
    else $error("ready kept after disable");
  cover property (modeWr);
  cover property ($rose(dfReady));
  cover property (seqBusy [*5]);
endmodule
bind flash_mode_ctrl flash_mode_monitor #(.MODE_SETTLE_CYCLES(MODE_SETTLE_CYCLES)) mon (.mclk, .arst_n, .devReq,
  .devRdata, .seqBusy, .extraBusy, .cpuIntEn, .dfReady);

// [bench/flash_dev_model.sv]
// behavioural model of the flash device register port
module flash_dev_model (
  input  wire logic                     mclk,
  input  wire logic                     arst_n,
  input  wire flash_mode_pkg::dev_req_t devReq,
  input  wire logic                     holdMode,
  output logic [7:0]                    devRdata,
  output logic                          dfReadOk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] dfCtl_reg, modeCtl_reg, freqSet_reg, idle_reg;
  // data-flash reads open only while the enable bit is set
  assign dfReadOk = dfCtl_reg[0];
  // the port answers in the cycle of the read strobe; between reads it shows
  // a toggling pattern that matches no mode, so a late sample is caught
  always_comb begin
    devRdata = idle_reg;
    if (devReq.re)
      devRdata = devReq.addr == 8'h01 ? modeCtl_reg : devReq.addr == 8'h00 ? dfCtl_reg : freqSet_reg;
  end
  // holdMode ignores mode writes, like a sequencer that refuses a change
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dfCtl_reg   <= 8'h00;
      modeCtl_reg <= 8'h08;
      freqSet_reg <= 8'h00;
      idle_reg    <= 8'h00;
    end else begin
      idle_reg <= ~idle_reg;
      if (devReq.we && devReq.addr == 8'h00)
        dfCtl_reg <= devReq.wdata;
      if (devReq.we && devReq.addr == 8'h01 && !holdMode)
        modeCtl_reg <= devReq.wdata;
      if (devReq.we && devReq.addr == 8'h02)
        freqSet_reg <= devReq.wdata;
    end
  end
endmodule

// [bench/tb_flash_mode_and_dataflash_access.sv]
// self-checking bench for the flash mode controller
module tb_flash_mode_and_dataflash_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     mclk, arst_n, swWe, swRe, seqBusy, extraBusy, holdMode, cpuIntEn, dfReady, irq, dfReadOk;
  logic [7:0]               swAddr, devRdata, expMode, expFreq;
  logic [31:0]              swWdata, swRdata, rd;
  flash_mode_pkg::dev_req_t devReq;
  int                       error_cnt = 0, checked = 0, seed = 32'h9b8f, f, i;
  int                       fl[7] = '{1, 41, 2, 23, 24, 40, 0};
  logic [7:0]               cs[8] = '{8'h01, 8'h02, 8'h03, 8'h02, 8'h01, 8'h04, 8'h01, 8'h07};

  flash_mode_ctrl #(.MODE_SETTLE_CYCLES(2)) DUT (.mclk, .arst_n, .swAddr, .swWdata, .swWe, .swRe, .swRdata, .devReq,
    .devRdata, .seqBusy, .extraBusy, .cpuIntEn, .dfReady, .irq);
  flash_dev_model dev (.mclk, .arst_n, .devReq, .holdMode, .devRdata, .dfReadOk);

  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask

  // level outputs {cpuIntEn, dfReady, irq}, looked at once settled
  task automatic pins(input logic [2:0] exp);
    repeat (3) @(posedge mclk);
    #1;
    checked++;
    if ({cpuIntEn, dfReady, irq} !== exp) begin
      error_cnt++;
      $display("ERROR %0t levels %b expected %b", $time, {cpuIntEn, dfReady, irq}, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    swAddr  <= a;
    swWdata <= d;
    swWe    <= 1'b1;
    @(posedge mclk);
    swWe <= 1'b0;
  endtask

  task automatic rdReg(input logic [7:0] a);
    @(posedge mclk);
    swAddr <= a;
    swRe   <= 1'b1;
    @(posedge mclk);
    swRe <= 1'b0;
    #1 rd = swRdata;
  endtask

  // issue a command, poll busy under a bound, check the result code
  task automatic cmd(input logic [2:0] op, input logic [7:0] arg, input logic [7:0] res);
    int n;
    n = 0;
    wr(flash_mode_pkg::A_CMD, {16'h0, arg, 5'h0, op});
    do begin
      rdReg(flash_mode_pkg::A_STATUS);
      n++;
    end while (rd[0] !== 1'b0 && n < 500);
    cmp({16'h0, rd[15:8], 7'h0, rd[0]}, {16'h0, res, 8'h0});
  endtask

  function automatic logic [7:0] want(input logic [7:0] c);
    return c == 8'h01 ? 8'h82 : c == 8'h02 ? 8'h10 : 8'h08;
  endfunction

  // reference for a mode change: programming only from non-programmable
  task automatic modeStep(input logic [7:0] code);
    logic [7:0] res;
    res = 8'h00;
    if (want(code) != 8'h08 && expMode != 8'h08)
      res = 8'h11;
    else if (!holdMode)
      expMode = want(code);
    else if (expMode != want(code))
      res = 8'h11;
    cmd(flash_mode_pkg::OP_MODE, code, res);
    cmp({24'h0, dev.modeCtl_reg}, {24'h0, expMode});
    cmp({24'h0, dev.freqSet_reg}, {24'h0, expFreq});
  endtask

  initial begin
    {swWe, swRe, seqBusy, extraBusy, holdMode, arst_n, swAddr, swWdata} = '0;
    {expMode, expFreq} = {8'h08, 8'h00};
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    rdReg(flash_mode_pkg::A_STATUS);
    cmp(rd, 32'h0);
    rdReg(8'h3c);
    cmp(rd, 32'h0);
    wr(flash_mode_pkg::A_CTRL, 32'h1);
    cmd(flash_mode_pkg::OP_MODE, 8'h01, 8'h10);
    for (i = 0; i < 7; i++) begin
      f = i == 6 ? 2 + {$random(seed)} % 39 : fl[i];
      expFreq = f >= 2 && f <= 40 ? (f <= 23 ? 8'(f - 1) : 8'((f + 23) >> 1)) : expFreq;
      cmd(flash_mode_pkg::OP_INIT, 8'(f), f >= 2 && f <= 40 ? 8'h00 : 8'h10);
      rdReg(flash_mode_pkg::A_FREQ);
      cmp(rd, {24'h0, expFreq});
    end
    // sticky events stay hidden while masked
    pins(3'b100);
    wr(flash_mode_pkg::A_IRQMASK, 32'h3);
    pins(3'b101);
    wr(flash_mode_pkg::A_IRQSTAT, 32'h3);
    wr(flash_mode_pkg::A_IRQMASK, 32'h0);
    cmd(flash_mode_pkg::OP_DFACC, 8'h01, 8'h00);
    pins(3'b110);
    cmp({31'h0, dfReadOk}, 32'h1);
    cmd(flash_mode_pkg::OP_DFACC, 8'h05 + 8'({$random(seed)} % 200), 8'h00);
    pins(3'b100);
    cmp({31'h0, dfReadOk}, 32'h0);
    cmd(flash_mode_pkg::OP_DFACC, flash_mode_pkg::ACCESS_ENABLE_REQ, 8'h00);
    cmd(flash_mode_pkg::OP_DFACC, flash_mode_pkg::ACCESS_DISABLE_REQ, 8'h00);
    pins(3'b100);
    cmp({31'h0, dfReadOk}, 32'h0);
    for (i = 0; i < 8; i++) begin
      modeStep(cs[i]);
      cmd(flash_mode_pkg::OP_CHECK, cs[i], want(cs[i]) == expMode ? 8'h00 : 8'h11);
      if (expMode != 8'h08)
        cmd(flash_mode_pkg::OP_DFACC, 8'h01, 8'h11);
    end
    // each sequencer busy in turn holds the mode change back
    for (i = 0; i < 2; i++) begin
      @(posedge mclk);
      {seqBusy, extraBusy} <= i ? 2'b01 : 2'b10;
      fork
        modeStep(8'h01);
        begin
          repeat (40) @(posedge mclk);
          cmp({24'h0, dev.modeCtl_reg}, 32'h08);
          {seqBusy, extraBusy} <= 2'b00;
        end
      join
      modeStep(8'h03);
    end
    holdMode <= 1'b1;
    @(posedge mclk);
    modeStep(8'h02);
    holdMode <= 1'b0;
    wr(flash_mode_pkg::A_CTRL, 32'h0);
    pins(3'b000);
    stop_test();
  end

  // watchdog sized well above the longest expected run
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
endmodule
